// ---- common/scps_defs.vh ----
// constants for the smart card power sequencer
`ifndef SCPS_DEFS_VH
`define SCPS_DEFS_VH
// ==========================================================
// register byte offsets
`define SCPS_ADR_CTRL 4'h0
`define SCPS_ADR_STAT 4'h4
`define SCPS_ADR_IRQ 4'h8
`define SCPS_ADR_MASK 4'hc
// ==========================================================
// control fields
`define SCPS_CTRL_CMD_N 0
`define SCPS_CTRL_VSEL 1
`define SCPS_CTRL_RLO 2
`define SCPS_CTRL_RHI 3
`define SCPS_CTRL_LVLSEL 4
`define SCPS_CTRL_RESET 5'h11
// ==========================================================
// event bits
`define SCPS_EV_ACT 0
`define SCPS_EV_DEACT 1
`define SCPS_EV_UV 2
`define SCPS_EV_SHORT 3
`define SCPS_EV_TEMP 4
`define SCPS_EV_REMOVE 5
`define SCPS_EV_W 6
// ==========================================================
// timing
`define SCPS_CLK_MHZ 40
`define SCPS_UV_FILTER_NS 20000
`define SCPS_UV_FILTER_CYC ((`SCPS_UV_FILTER_NS * `SCPS_CLK_MHZ) / 1000)
`define SCPS_STEP_CYC 16
`endif

// ---- hw/scps_sequencer.v ----
// smart card activation / deactivation sequencer with wishbone registers
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "scps_defs.vh"
module scps_sequencer #(
  parameter STEP_CYC = `SCPS_STEP_CYC,
  parameter UV_FILTER_CYC = `SCPS_UV_FILTER_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire irq_o,
  input wire card_present_input_i,
  input wire undervolt_upper_i,
  input wire undervolt_lower_i,
  input wire over_temp_i,
  input wire short_circuit_i,
  input wire card_io_i,
  input wire host_io_i,
  output reg host_io_o,
  output reg pump_output_o,
  output reg card_vcc_en_o,
  output reg card_voltage_5v_o,
  output reg card_rst_n_o,
  output wire card_clk_o,
  output reg card_io_o,
  output reg card_io_oe_o,
  output reg fault_n_o
);
  // ==========================================================
  // states
  localparam S_IDLE = 3'h0;
  localparam S_PUMP = 3'h1;
  localparam S_VCC = 3'h2;
  localparam S_IOCLK = 3'h3;
  localparam S_ACTIVE = 3'h4;
  localparam S_D_RST = 3'h5;
  localparam S_D_CLK = 3'h6;
  localparam S_D_IO = 3'h7;
  // ==========================================================
  // sized copies of the counts, so every compare stays 16 bits wide
  localparam [31:0] STEP_CYC32 = STEP_CYC;
  localparam [31:0] UV_CYC32 = UV_FILTER_CYC;
  localparam [15:0] STEP_LAST = STEP_CYC32[15:0] - 16'h0001;
  localparam [15:0] UV_LIMIT = UV_CYC32[15:0];
  // ==========================================================
  // state groups shared by the outputs
  // supply stays on through the first two deactivation steps
  function powered;
    input [2:0] st;
    begin
      powered = (st == S_VCC) || (st == S_IOCLK) || (st == S_ACTIVE) ||
                (st == S_D_RST) || (st == S_D_CLK);
    end
  endfunction
  // io is released in the same step as the supply drops
  function io_driven;
    input [2:0] st;
    begin
      io_driven = (st == S_IOCLK) || (st == S_ACTIVE) || (st == S_D_RST) ||
                  (st == S_D_CLK);
    end
  endfunction
  function clocked;
    input [2:0] st;
    begin
      clocked = (st == S_IOCLK) || (st == S_ACTIVE) || (st == S_D_RST);
    end
  endfunction
  // ==========================================================
  // pin synchronisers; first stage feeds only the second
  reg [5:0] sy1_reg;
  reg [5:0] sy2_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      sy1_reg <= 6'h00;
      sy2_reg <= 6'h00;
    end else begin
      sy1_reg <= {card_io_i, host_io_i, short_circuit_i, over_temp_i,
                  undervolt_lower_i, undervolt_upper_i};
      sy2_reg <= sy1_reg;
    end
  end
  reg pres1_reg;
  reg pres2_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      pres1_reg <= 1'b0;
      pres2_reg <= 1'b0;
    end else begin
      pres1_reg <= card_present_input_i;
      pres2_reg <= pres1_reg;
    end
  end
  wire uv_hi = sy2_reg[0];
  wire uv_lo = sy2_reg[1];
  wire temp = sy2_reg[2];
  wire shrt = sy2_reg[3];
  wire hio = sy2_reg[4];
  wire cio = sy2_reg[5];
  // ==========================================================
  // registers
  reg [4:0] ctrl_reg;
  reg [`SCPS_EV_W-1:0] irq_reg;
  reg [`SCPS_EV_W-1:0] mask_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  wire supply_command_n = ctrl_reg[`SCPS_CTRL_CMD_N];
  wire undervolt_level_select = ctrl_reg[`SCPS_CTRL_LVLSEL];
  wire [1:0] ratio_sel = {ctrl_reg[`SCPS_CTRL_RHI], ctrl_reg[`SCPS_CTRL_RLO]};
  // ==========================================================
  // undervoltage supervisor
  reg [15:0] uv_cnt_reg;
  always @(posedge clk_i) begin
    if (rst_i || !uv_lo) begin
      // any recovery restarts the filter, so short spikes never add up
      uv_cnt_reg <= 16'h0000;
    end else if (uv_cnt_reg <= UV_LIMIT) begin
      // saturates one past the limit so a long sag cannot wrap to clear
      uv_cnt_reg <= uv_cnt_reg + 16'h0001;
    end
  end
  wire uv_fault = undervolt_level_select ? uv_hi :
                  (uv_cnt_reg > UV_LIMIT);
  wire removed = !pres2_reg;
  wire hard_fault = uv_fault | temp | removed;
  wire sequencing = (state_reg == S_PUMP) || (state_reg == S_VCC) ||
                    (state_reg == S_IOCLK);
  // short is held off until activation completes
  wire short_act = shrt && !sequencing;
  wire any_fault = hard_fault | short_act;
  // ==========================================================
  // sequencer
  reg [15:0] step_reg;
  wire step_done = (step_reg == STEP_LAST);
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (pres2_reg && !supply_command_n && !hard_fault)
          state_next = S_PUMP;
      end
      S_PUMP: begin
        if (hard_fault)
          state_next = S_D_RST;
        else if (step_done)
          state_next = S_VCC;
      end
      S_VCC: begin
        if (hard_fault)
          state_next = S_D_RST;
        else if (step_done)
          state_next = S_IOCLK;
      end
      S_IOCLK: begin
        if (hard_fault)
          state_next = S_D_RST;
        else if (step_done)
          state_next = S_ACTIVE;
      end
      S_ACTIVE: begin
        if (supply_command_n || any_fault)
          state_next = S_D_RST;
      end
      // deactivation always runs to the end; a new command waits for idle
      S_D_RST: begin
        if (step_done)
          state_next = S_D_CLK;
      end
      S_D_CLK: begin
        if (step_done)
          state_next = S_D_IO;
      end
      S_D_IO: begin
        if (step_done)
          state_next = S_IDLE;
      end
      default: state_next = S_IDLE;
    endcase
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      step_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg || state_reg == S_IDLE || state_reg == S_ACTIVE)
        step_reg <= 16'h0000;
      else
        step_reg <= step_reg + 16'h0001;
    end
  end
  // ==========================================================
  // card clock divider
  reg [2:0] div_reg;
  reg [1:0] ratio_reg;
  reg clk_div_reg;
  function [2:0] half_period;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: half_period = 3'h3;
        2'b01: half_period = 3'h1;
        2'b11: half_period = 3'h0;
        default: half_period = 3'h0;
      endcase
    end
  endfunction
  wire clk_on = clocked(state_reg);
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 3'h0;
      ratio_reg <= 2'b00;
      clk_div_reg <= 1'b0;
    end else if (!clk_on) begin
      div_reg <= 3'h0;
      clk_div_reg <= 1'b0;
      ratio_reg <= ratio_sel;
    end else if (ratio_reg == 2'b10) begin
      // undivided: oscillator rate cannot be made from a register, so
      // the output gates the clock below; switch away only while low
      div_reg <= 3'h0;
      clk_div_reg <= 1'b0;
      ratio_reg <= ratio_sel;
    end else if (div_reg == half_period(ratio_reg)) begin
      div_reg <= 3'h0;
      clk_div_reg <= ~clk_div_reg;
      if (clk_div_reg)
        ratio_reg <= ratio_sel;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end
  // direct ratio: gated oscillator, glitch-free since gate changes when clk low
  reg full_gate_reg;
  always @(negedge clk_i) begin
    if (rst_i)
      full_gate_reg <= 1'b0;
    else
      full_gate_reg <= clk_on && (ratio_reg == 2'b10);
  end
  wire card_clk_full = clk_i & full_gate_reg;
  // only one of the two sources can be high at a time
  assign card_clk_o = clk_div_reg | card_clk_full;
  // ==========================================================
  // outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      pump_output_o <= 1'b0;
      card_vcc_en_o <= 1'b0;
      card_voltage_5v_o <= 1'b0;
      card_rst_n_o <= 1'b0;
      card_io_o <= 1'b0;
      card_io_oe_o <= 1'b0;
      fault_n_o <= 1'b1;
      host_io_o <= 1'b1;
    end else begin
      // pump from first step; pump path only for 5V cards
      pump_output_o <= (state_reg != S_IDLE) && (state_reg != S_D_IO) &&
                       ctrl_reg[`SCPS_CTRL_VSEL];
      card_voltage_5v_o <= ctrl_reg[`SCPS_CTRL_VSEL];
      card_vcc_en_o <= powered(state_reg);
      card_rst_n_o <= (state_next == S_ACTIVE);
      // io released at the t13 step
      card_io_oe_o <= io_driven(state_reg);
      card_io_o <= hio;
      // card data reaches the host only while active; otherwise idle high
      host_io_o <= (state_reg == S_ACTIVE) ? cio : 1'b1;
      if (any_fault && state_reg != S_IDLE)
        fault_n_o <= 1'b0;
      else if (state_reg == S_IDLE && supply_command_n)
        fault_n_o <= 1'b1;
    end
  end
  // ==========================================================
  // events
  wire [`SCPS_EV_W-1:0] ev;
  assign ev[`SCPS_EV_ACT] = (state_reg == S_IOCLK) && (state_next == S_ACTIVE);
  assign ev[`SCPS_EV_DEACT] = (state_reg == S_D_IO) && (state_next == S_IDLE);
  assign ev[`SCPS_EV_UV] = uv_fault && (state_reg != S_IDLE);
  assign ev[`SCPS_EV_SHORT] = short_act && (state_reg == S_ACTIVE);
  assign ev[`SCPS_EV_TEMP] = temp && (state_reg != S_IDLE);
  assign ev[`SCPS_EV_REMOVE] = removed && (state_reg != S_IDLE);
  assign irq_o = |(irq_reg & mask_reg);
  // ==========================================================
  // wishbone slave, one wait state
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_reg <= `SCPS_CTRL_RESET;
      irq_reg <= {`SCPS_EV_W{1'b0}};
      mask_reg <= {`SCPS_EV_W{1'b0}};
    end else begin
      wb_ack_o <= wb_req;
      if (wb_wr && wb_adr_i == `SCPS_ADR_CTRL)
        ctrl_reg <= wb_dat_i[4:0];
      if (wb_wr && wb_adr_i == `SCPS_ADR_MASK)
        mask_reg <= wb_dat_i[`SCPS_EV_W-1:0];
      // set wins over write-one-to-clear
      if (wb_wr && wb_adr_i == `SCPS_ADR_IRQ)
        irq_reg <= (irq_reg & ~wb_dat_i[`SCPS_EV_W-1:0]) | ev;
      else
        irq_reg <= irq_reg | ev;
      case (wb_adr_i)
        `SCPS_ADR_CTRL: wb_dat_o <= {27'h0, ctrl_reg};
        `SCPS_ADR_STAT: wb_dat_o <= {24'h000000, pres2_reg, fault_n_o,
                                     card_rst_n_o, card_vcc_en_o, state_reg, 1'b0};
        `SCPS_ADR_IRQ: wb_dat_o <= {26'h0, irq_reg};
        `SCPS_ADR_MASK: wb_dat_o <= {26'h0, mask_reg};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- dv/scps_card_model.sv ----
// stand-in for the contact card on the shared io line
`timescale 1ns/1ps
`default_nettype none
// ==========
// card model
module scps_card_model (
  input wire logic card_clk_i,
  input wire logic powered_i,
  input wire logic dev_io_i,
  input wire logic dev_oe_i,
  output logic line_o
);
  logic [2:0] bit_cnt = 3'h0;
  // the card only talks on its own clock, so a stopped clock freezes it
  always @(posedge card_clk_i) bit_cnt <= bit_cnt + 3'h1;
  // line has a pull-up: released and unpowered it reads high
  always_comb begin
    if (dev_oe_i) line_o = dev_io_i;
    else if (powered_i) line_o = bit_cnt[1];
    else line_o = 1'b1;
  end
endmodule
`default_nettype wire

// ---- dv/scps_assertions.sv ----
// port checker for the card power sequencer
`timescale 1ns/1ps
`default_nettype none
// ==========
// checker
module scps_checker (
  input wire clk_i,
  input wire rst_i,
  input wire pump_output_o,
  input wire card_vcc_en_o,
  input wire card_voltage_5v_o,
  input wire card_rst_n_o,
  input wire card_clk_o,
  input wire card_io_oe_o,
  input wire over_temp_i,
  input wire short_circuit_i,
  input wire fault_n_o,
  input wire host_io_i,
  input wire host_io_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_pump; $rose(card_vcc_en_o) && card_voltage_5v_o |-> $past(pump_output_o); endproperty
  a_pump: assert property (p_pump) else $error("supply on before pump");
  property p_rst; $rose(card_rst_n_o) |-> $past(card_vcc_en_o, 2); endproperty
  a_rst: assert property (p_rst) else $error("reset released early");
  property p_hiz; $fell(card_rst_n_o) |-> ##[1:40] !card_io_oe_o; endproperty
  a_hiz: assert property (p_hiz) else $error("io still driven");
  property p_clk; card_clk_o |-> card_vcc_en_o; endproperty
  a_clk: assert property (p_clk) else $error("clock while unpowered");
  property p_off; !card_vcc_en_o |-> !card_rst_n_o && !card_io_oe_o; endproperty
  a_off: assert property (p_off) else $error("card not quiet while off");
  property p_io;
    card_rst_n_o && $past(card_rst_n_o, 7) |-> host_io_o == $past(host_io_i, 6);
  endproperty
  a_io: assert property (p_io) else $error("io not passed while active");
  property p_sh; card_rst_n_o && short_circuit_i |-> ##[1:8] !card_rst_n_o; endproperty
  a_sh: assert property (p_sh) else $error("short not acted on");
  property p_shf; card_rst_n_o && short_circuit_i |-> ##[1:8] !fault_n_o; endproperty
  a_shf: assert property (p_shf) else $error("short not flagged");
  property p_tmp; card_rst_n_o && over_temp_i |-> ##[1:8] !fault_n_o; endproperty
  a_tmp: assert property (p_tmp) else $error("heat not flagged");
endmodule
bind scps_sequencer scps_checker scps_checker_i (.clk_i(clk_i), .rst_i(rst_i),
  .pump_output_o(pump_output_o), .card_vcc_en_o(card_vcc_en_o),
  .card_voltage_5v_o(card_voltage_5v_o), .card_rst_n_o(card_rst_n_o),
  .card_clk_o(card_clk_o), .card_io_oe_o(card_io_oe_o), .over_temp_i(over_temp_i),
  .short_circuit_i(short_circuit_i), .fault_n_o(fault_n_o), .host_io_i(host_io_i),
  .host_io_o(host_io_o));
`default_nettype wire

// ---- dv/scps_sequencer_tb_top.sv ----
// self-checking bench for the card power sequencer
`timescale 1ns/1ps
`default_nettype none
`include "scps_defs.vh"
// ==========
// bench top
module scps_sequencer_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic card_present_input_i = 1'b0, undervolt_upper_i = 1'b0, undervolt_lower_i = 1'b0;
  logic over_temp_i = 1'b0, short_circuit_i = 1'b0, host_io_i = 1'b1, clk_q;
  logic wb_ack_o, irq_o, host_io_o, pump_output_o, card_vcc_en_o, card_voltage_5v_o;
  logic card_rst_n_o, card_clk_o, card_io_o, card_io_oe_o, fault_n_o, card_io_i;
  logic [31:0] exp_q[$], msk_q[$];
  int mismatches = 0, n_tests = 0, k, n, r, m;
  int evb[6] = '{2, 2, 4, 3, 5, 1};
  wire logic [3:0] pins = {fault_n_o, card_io_oe_o, card_vcc_en_o, card_rst_n_o};
  scps_sequencer #(.STEP_CYC(2), .UV_FILTER_CYC(8)) scps_sequencer_i (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .card_present_input_i(card_present_input_i),
    .undervolt_upper_i(undervolt_upper_i), .undervolt_lower_i(undervolt_lower_i),
    .over_temp_i(over_temp_i), .short_circuit_i(short_circuit_i), .card_io_i(card_io_i),
    .host_io_i(host_io_i), .host_io_o(host_io_o), .pump_output_o(pump_output_o),
    .card_vcc_en_o(card_vcc_en_o), .card_voltage_5v_o(card_voltage_5v_o),
    .card_rst_n_o(card_rst_n_o), .card_clk_o(card_clk_o), .card_io_o(card_io_o),
    .card_io_oe_o(card_io_oe_o), .fault_n_o(fault_n_o));
  scps_card_model scps_card_model_i (.card_clk_i(card_clk_o), .powered_i(card_vcc_en_o),
    .dev_io_i(card_io_o), .dev_oe_i(card_io_oe_o), .line_o(card_io_i));
  initial forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) host_io_i <= 1'($urandom);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // reads note their expected value; the watcher compares at the ack edge
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, m);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    if (!we) exp_q.push_back(d);
    if (!we) msk_q.push_back(m);
    n = 0;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 20);
    if (wb_ack_o !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && !wb_we_i && exp_q.size() > 0) begin
      check("read data", wb_dat_o & msk_q.pop_front(), exp_q.pop_front());
    end
  end
  task automatic wait_for(input int i, input logic v);
    for (n = 0; n < 400 && pins[i] !== v; n++) @(posedge clk_i);
    check("card pin", pins[i], v);
    if (pins[i] !== v) report_and_stop();
  endtask
  // leave the command high until idle so it is never re-lowered mid-sequence
  task automatic activate(input logic [4:0] c);
    wb(1'b1, `SCPS_ADR_CTRL, {27'h0, c | 5'h01}, 32'h0);
    wait_for(1, 1'b0);
    wb(1'b1, `SCPS_ADR_CTRL, {27'h0, c}, 32'h0);
    wait_for(0, 1'b1);
  endtask
  initial begin
    void'($urandom(32'h4f6b1166));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `SCPS_ADR_CTRL, 32'h11, 32'h1f);
    wb(1'b0, 4'h2, 32'h0, 32'hffffffff);
    wb(1'b1, `SCPS_ADR_MASK, 32'h3f, 32'h0);
    wb(1'b1, `SCPS_ADR_CTRL, 32'h10, 32'h0);
    repeat (40) @(posedge clk_i);
    check("supply without card", card_vcc_en_o, 1'b0);
    wb(1'b1, `SCPS_ADR_CTRL, 32'h11, 32'h0);
    card_present_input_i <= 1'b1;
    activate(5'h12);
    check("pump", pump_output_o, 1'b1);
    check("card at 5V", card_voltage_5v_o, 1'b1);
    check("irq raised", irq_o, 1'b1);
    wb(1'b1, `SCPS_ADR_IRQ, 32'h1, 32'h0);
    wb(1'b0, `SCPS_ADR_IRQ, 32'h0, 32'h1);
    check("irq cleared", irq_o, 1'b0);
    for (k = 0; k < 6; k++) begin
      r = $urandom % 4;
      wb(1'b1, `SCPS_ADR_CTRL, {28'h1, r[1:0], 2'b10}, 32'h0);
      repeat (20) @(posedge clk_i);
      m = 0;
      clk_q = card_clk_o;
      repeat (64) begin
        @(posedge clk_i);
        m += (card_clk_o === 1'b1 && clk_q === 1'b0);
        clk_q = card_clk_o;
      end
      check("clock rises", m, r == 0 ? 8 : r == 1 ? 16 : r == 3 ? 32 : 0);
    end
    for (k = 0; k < 6; k++) begin
      activate(k == 1 ? 5'h00 : 5'h10);
      wb(1'b1, `SCPS_ADR_IRQ, 32'h3f, 32'h0);
      {undervolt_upper_i, undervolt_lower_i, over_temp_i, short_circuit_i} <= 4'(8 >> k);
      card_present_input_i <= k != 4;
      if (k == 5) wb(1'b1, `SCPS_ADR_CTRL, 32'h11, 32'h0);
      if (k == 1) repeat (4) @(posedge clk_i);
      if (k == 1) check("filtered undervolt", card_rst_n_o, 1'b1);
      wait_for(0, 1'b0);
      check("fault flag", fault_n_o, k == 5);
      wait_for(1, 1'b0);
      check("clock stopped", card_clk_o, 1'b0);
      check("io released", card_io_oe_o, 1'b0);
      wb(1'b0, `SCPS_ADR_IRQ, 32'h1 << evb[k], 32'h1 << evb[k]);
      {undervolt_upper_i, undervolt_lower_i, over_temp_i, short_circuit_i} <= 4'h0;
      card_present_input_i <= 1'b1;
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
